// ==== core/sqs_apb_slave.v ====
// APB slave front end: handshake, no wait state, registered answer.
// Assumes the owner supplies read data and an error flag for the
// address on the bus during the setup phase.
`default_nettype none

module sqs_apb_slave #(
	parameter ADDR_W = 8
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [31:0] rd_data_in,
	input wire err_in,
	output wire setup_out,
	output wire commit_out,
	output reg [31:0] prdata_out,
	output reg pready_out,
	output reg pslverr_out
);

	// Setup phase: answer is prepared here so prdata_out, pready_out and pslverr_out are flops
	assign setup_out = psel_in & ~penable_in;
	// Write or read completes only at the edge that sees pready high
	assign commit_out = psel_in & penable_in & pready_out;

	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			prdata_out <= 32'h00000000;
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end else if (setup_out) begin
			prdata_out <= pwrite_in ? 32'h00000000 : rd_data_in;
			pready_out <= 1'b1;
			pslverr_out <= err_in;
		end else if (commit_out) begin
			// Drop the answer so a following setup starts clean
			prdata_out <= 32'h00000000;
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end
	end

endmodule // sqs_apb_slave

`default_nettype wire

// ==== core/sqs_top.v ====
// Sequencer stack slice: entries for slots 4 to 7 with an APB slave
// and the stepping logic that picks one channel pair per conversion.
// Assumes conversion start and done pulses come from same-clock logic.
//
// Design decision made here: register access over APB.
`include "sqs_map.vh"
`default_nettype none

module sqs_top #(
	parameter ADDR_W = 8,
	parameter CH_W = 4
) (
	input wire CLOCK_IN,
	input wire RST_N_IN,
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [ADDR_W-1:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	input wire [3:0] PSTRB_IN,
	output wire [31:0] PRDATA_OUT,
	output wire PREADY_OUT,
	output wire PSLVERR_OUT,
	input wire CONV_START_IN,
	input wire CONV_DONE_IN,
	output reg [CH_W-1:0] CONVERTER_A_CHANNEL_OUT,
	output reg [CH_W-1:0] CONVERTER_B_CHANNEL_OUT,
	output reg ACCESS_WRITE_OUT,
	output reg [5:0] ENTRY_ADDRESS_OUT,
	output reg [2:0] ACTIVE_SLOT_OUT,
	output reg RETURN_TO_FIRST_OUT,
	output reg BUSY_OUT
);

	localparam ST_IDLE = 1'b0;
	localparam ST_CONVERT = 1'b1;
	localparam [15:0] RST_ENTRY_4 = `SQS_RST_SLOT_4;

	// Entry storage, index 0 is slot 4
	reg [15:0] slot_reg [0:3];
	reg [31:0] control_reg;
	reg state_reg;
	reg state_next;
	reg [1:0] ptr_reg;
	reg [1:0] ptr_next;
	reg enable_d_reg;

	wire setup;
	wire commit;
	wire [5:0] index;
	wire [2:0] sel_slot;
	wire word_ok;
	reg [31:0] rd_data;
	reg err;
	reg [15:0] cur_entry;
	reg [15:0] next_entry;
	reg wrap;
	wire enable;
	wire enable_rise;
	integer i;

	// Word address; low two bits must be zero for a hit
	assign index = PADDR_IN[7:2];
	assign word_ok = (PADDR_IN[1:0] == 2'b00);
	assign sel_slot = slot_of(index);
	assign enable = control_reg[`SQS_F_ENABLE];
	assign enable_rise = enable & ~enable_d_reg;

	// Index of an entry register, or 3'h4 when not an entry
	function [2:0] slot_of;
		input [5:0] idx;
		begin
			case (idx)
				`SQS_IDX_SLOT_4: slot_of = 3'h0;
				`SQS_IDX_SLOT_5: slot_of = 3'h1;
				`SQS_IDX_SLOT_6: slot_of = 3'h2;
				`SQS_IDX_SLOT_7: slot_of = 3'h3;
				default: slot_of = 3'h4;
			endcase
		end
	endfunction

	// A write that sets byte 1 must carry the entry's own address field to land
	function addr_match;
		input [15:0] data;
		input [5:0] idx;
		begin
			addr_match = (data[`SQS_F_ADDR_HI:`SQS_F_ADDR_LO] == idx);
		end
	endfunction

	// Byte lanes merged into the 16-bit entry
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] wdata;
		input [3:0] strb;
		begin
			merge16[7:0] = strb[0] ? wdata[7:0] : old[7:0];
			merge16[15:8] = strb[1] ? wdata[15:8] : old[15:8];
		end
	endfunction

	sqs_apb_slave #(
		.ADDR_W(ADDR_W)
	) u_apb (
		.clk_in(CLOCK_IN),
		.rst_n_in(RST_N_IN),
		.psel_in(PSEL_IN),
		.penable_in(PENABLE_IN),
		.pwrite_in(PWRITE_IN),
		.rd_data_in(rd_data),
		.err_in(err),
		.setup_out(setup),
		.commit_out(commit),
		.prdata_out(PRDATA_OUT),
		.pready_out(PREADY_OUT),
		.pslverr_out(PSLVERR_OUT)
	);

	// Read mux and error decision for the address on the bus
	always @* begin
		rd_data = 32'h00000000;
		err = 1'b0;
		if (!word_ok) begin
			err = 1'b1;
		end else if (sel_slot != 3'h4) begin
			rd_data = {16'h0000, slot_reg[sel_slot[1:0]]};
			// Refuse a write whose address field names another entry
			if (PWRITE_IN && PSTRB_IN[1] &&
				!addr_match(PWDATA_IN[15:0], index)) begin
				err = 1'b1;
			end
		end else if (index == `SQS_IDX_CONTROL) begin
			rd_data = control_reg;
		end else if (index == `SQS_IDX_STATUS) begin
			rd_data[`SQS_F_ST_SLOT_HI:`SQS_F_ST_SLOT_LO] = ACTIVE_SLOT_OUT;
			rd_data[`SQS_F_ST_BUSY] = BUSY_OUT;
			if (PWRITE_IN) begin
				err = 1'b1;
			end
		end else begin
			err = 1'b1;
		end
	end

	// Register writes land only at the completing edge without error
	always @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			slot_reg[0] <= `SQS_RST_SLOT_4;
			slot_reg[1] <= `SQS_RST_SLOT_5;
			slot_reg[2] <= `SQS_RST_SLOT_6;
			slot_reg[3] <= `SQS_RST_SLOT_7;
			control_reg <= `SQS_RST_CONTROL;
		end else if (commit && PWRITE_IN && !PSLVERR_OUT) begin
			for (i = 0; i < 4; i = i + 1) begin
				if (slot_of(index) == i[2:0]) begin
					// All fields stored, direction bit included
					slot_reg[i] <= merge16(slot_reg[i], PWDATA_IN, PSTRB_IN);
				end
			end
			if (index == `SQS_IDX_CONTROL && PSTRB_IN[0]) begin
				control_reg <= {31'h00000000, PWDATA_IN[`SQS_F_ENABLE]};
			end
		end
	end

	// Entry in use now and the one the sequencer would take next
	always @* begin
		cur_entry = slot_reg[ptr_reg];
		wrap = cur_entry[`SQS_F_RETURN];
		if (wrap) begin
			ptr_next = 2'b00;
		end else begin
			// Slot 7 with return clear falls back to slot 4 here
			ptr_next = ptr_reg + 2'b01;
		end
		next_entry = slot_reg[ptr_next];
	end

	// Sequencer stepping
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (enable && CONV_START_IN) begin
					state_next = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				if (CONV_DONE_IN) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		if (!enable) begin
			state_next = ST_IDLE;
		end
	end

	always @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			state_reg <= ST_IDLE;
			ptr_reg <= 2'b00;
			enable_d_reg <= 1'b0;
			BUSY_OUT <= 1'b0;
			RETURN_TO_FIRST_OUT <= 1'b0;
			ACTIVE_SLOT_OUT <= `SQS_FIRST_SLOT;
			CONVERTER_A_CHANNEL_OUT <= RST_ENTRY_4[`SQS_F_CHA_HI:`SQS_F_CHA_LO];
			CONVERTER_B_CHANNEL_OUT <= RST_ENTRY_4[`SQS_F_CHB_HI:`SQS_F_CHB_LO];
			ACCESS_WRITE_OUT <= 1'b0;
			ENTRY_ADDRESS_OUT <= `SQS_IDX_SLOT_4;
		end else begin
			state_reg <= state_next;
			enable_d_reg <= enable;
			BUSY_OUT <= (state_next == ST_CONVERT);
			RETURN_TO_FIRST_OUT <= 1'b0;
			if (!enable) begin
				// Held at the first entry while stopped
				ptr_reg <= 2'b00;
				ACTIVE_SLOT_OUT <= `SQS_FIRST_SLOT;
			end else if (enable_rise) begin
				// Fresh start picks up slot 4 as software left it
				ptr_reg <= 2'b00;
				ACTIVE_SLOT_OUT <= `SQS_FIRST_SLOT;
				CONVERTER_A_CHANNEL_OUT <= slot_reg[0][`SQS_F_CHA_HI:`SQS_F_CHA_LO];
				CONVERTER_B_CHANNEL_OUT <= slot_reg[0][`SQS_F_CHB_HI:`SQS_F_CHB_LO];
				ACCESS_WRITE_OUT <= slot_reg[0][`SQS_F_WRITE];
				ENTRY_ADDRESS_OUT <= slot_reg[0][`SQS_F_ADDR_HI:`SQS_F_ADDR_LO];
			end else if (state_reg == ST_CONVERT && CONV_DONE_IN) begin
				// Channels change after the conversion ends, and otherwise only at a fresh start
				ptr_reg <= ptr_next;
				ACTIVE_SLOT_OUT <= `SQS_FIRST_SLOT + {1'b0, ptr_next};
				RETURN_TO_FIRST_OUT <= wrap;
				CONVERTER_A_CHANNEL_OUT <= next_entry[`SQS_F_CHA_HI:`SQS_F_CHA_LO];
				CONVERTER_B_CHANNEL_OUT <= next_entry[`SQS_F_CHB_HI:`SQS_F_CHB_LO];
				ACCESS_WRITE_OUT <= next_entry[`SQS_F_WRITE];
				ENTRY_ADDRESS_OUT <= next_entry[`SQS_F_ADDR_HI:`SQS_F_ADDR_LO];
			end
		end
	end

endmodule // sqs_top

`default_nettype wire

// ==== pkg/sqs_map.vh ====
// Constants for the sequencer stack slice, slots 4 to 7.
// Assumes an 8-bit APB byte address and 32-bit data words.
`ifndef SQS_MAP_VH
`define SQS_MAP_VH

// Register indices as printed; byte address is four times the index
`define SQS_IDX_SLOT_4 6'h24
`define SQS_IDX_SLOT_5 6'h25
`define SQS_IDX_SLOT_6 6'h26
`define SQS_IDX_SLOT_7 6'h27
`define SQS_IDX_CONTROL 6'h28
`define SQS_IDX_STATUS 6'h29

// Reset values of the stack entries and the control register
`define SQS_RST_SLOT_4 16'h4844
`define SQS_RST_SLOT_5 16'h4A55
`define SQS_RST_SLOT_6 16'h4C66
`define SQS_RST_SLOT_7 16'h4F77
`define SQS_RST_CONTROL 32'h00000000

// Entry field positions
`define SQS_F_WRITE 15
`define SQS_F_ADDR_HI 14
`define SQS_F_ADDR_LO 9
`define SQS_F_RETURN 8
`define SQS_F_CHB_HI 7
`define SQS_F_CHB_LO 4
`define SQS_F_CHA_HI 3
`define SQS_F_CHA_LO 0

// Control and status field positions
`define SQS_F_ENABLE 0
`define SQS_F_ST_SLOT_LO 0
`define SQS_F_ST_SLOT_HI 2
`define SQS_F_ST_BUSY 3

// Slot number of the first entry held here
`define SQS_FIRST_SLOT 3'h4

`endif

// ==== test/sqs_top_monitor.sv ====
// Assertions on the sequencer stack slice ports.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none
module sqs_top_monitor #(
	parameter ADDR_W = 8,
	parameter CH_W = 4
) (
	input wire logic CLOCK_IN,
	input wire logic RST_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic CONV_START_IN,
	input wire logic CONV_DONE_IN,
	input wire logic PREADY_OUT,
	input wire logic BUSY_OUT,
	input wire logic RETURN_TO_FIRST_OUT,
	input wire logic [2:0] ACTIVE_SLOT_OUT,
	input wire logic [CH_W-1:0] CONVERTER_A_CHANNEL_OUT,
	input wire logic [CH_W-1:0] CONVERTER_B_CHANNEL_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (!RST_N_IN);
	a_ready_next: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
		else $error("No ready after setup");
	a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("Ready too long");
	a_step_next: assert property (CONV_DONE_IN && BUSY_OUT && ACTIVE_SLOT_OUT < 3'h7 |=>
		(ACTIVE_SLOT_OUT == $past(ACTIVE_SLOT_OUT) + 3'h1) || RETURN_TO_FIRST_OUT)
		else $error("Step not to next slot");
	a_return_first: assert property (RETURN_TO_FIRST_OUT |-> ACTIVE_SLOT_OUT == 3'h4)
		else $error("Return not to slot 4");
	a_done_idle: assert property (BUSY_OUT && CONV_DONE_IN |=> !BUSY_OUT)
		else $error("Busy after done");
	a_busy_start: assert property ($rose(BUSY_OUT) |-> $past(CONV_START_IN))
		else $error("Busy without start");
	a_chan_hold: assert property (BUSY_OUT && $past(BUSY_OUT) |->
		$stable(CONVERTER_A_CHANNEL_OUT) && $stable(CONVERTER_B_CHANNEL_OUT))
		else $error("Channels moved mid conversion");
	a_slot_legal: assert property (ACTIVE_SLOT_OUT >= 3'h4)
		else $error("Slot out of range");
endmodule // sqs_top_monitor
bind sqs_top sqs_top_monitor #(.ADDR_W(ADDR_W), .CH_W(CH_W)) u_mon (.CLOCK_IN(CLOCK_IN),
	.RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.CONV_START_IN(CONV_START_IN), .CONV_DONE_IN(CONV_DONE_IN), .PREADY_OUT(PREADY_OUT),
	.BUSY_OUT(BUSY_OUT), .RETURN_TO_FIRST_OUT(RETURN_TO_FIRST_OUT),
	.ACTIVE_SLOT_OUT(ACTIVE_SLOT_OUT), .CONVERTER_A_CHANNEL_OUT(CONVERTER_A_CHANNEL_OUT),
	.CONVERTER_B_CHANNEL_OUT(CONVERTER_B_CHANNEL_OUT));
`default_nettype wire

// ==== test/tb_sqs_top.sv ====
// Self-checking bench for the sequencer stack slice.
// Assumes sqs_top with APB access and start and done pulses.
`default_nettype none
module tb_sqs_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pw = 0, st = 0, dn = 0;
	logic [7:0] pa = 8'h00;
	logic [31:0] pd = 32'h00000000, rd, prd;
	logic [3:0] ps = 4'h0, cha, chb;
	logic e, prdy, perr, aw, rf, bsy;
	logic [5:0] ea;
	logic [2:0] sl;
	logic [7:0] bad [3] = '{8'h91, 8'hB0, 8'hA4};
	int n_errors = 0, n_checks = 0;
	sqs_top DUT (.CLOCK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pw), .PADDR_IN(pa), .PWDATA_IN(pd), .PSTRB_IN(ps), .PRDATA_OUT(prd),
		.PREADY_OUT(prdy), .PSLVERR_OUT(perr), .CONV_START_IN(st), .CONV_DONE_IN(dn),
		.CONVERTER_A_CHANNEL_OUT(cha), .CONVERTER_B_CHANNEL_OUT(chb), .ACCESS_WRITE_OUT(aw),
		.ENTRY_ADDRESS_OUT(ea), .ACTIVE_SLOT_OUT(sl), .RETURN_TO_FIRST_OUT(rf), .BUSY_OUT(bsy));
	initial begin
		forever #25 clk = ~clk;
	end
	task end_of_test;
		$display("Checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Bounded wait: a slave that never answers ends the run
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pw <= w;
		pa <= a;
		pd <= d;
		ps <= s;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (prdy !== 1'b1 && k < 16);
		rd = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (prdy !== 1'b1) begin
			n_errors++;
			end_of_test;
		end
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] x, input logic xe);
		apb(1'b0, a, 32'h00000000, 4'h0);
		chk(rd, x);
		chk(e, xe);
	endtask
	task outs(input logic [15:0] v, input logic [2:0] s);
		chk(cha, v[3:0]);
		chk(chb, v[7:4]);
		chk(ea, v[14:9]);
		chk(aw, v[15]);
		chk(sl, s);
	endtask
	task conv;
		@(posedge clk);
		st <= 1'b1;
		@(posedge clk);
		st <= 1'b0;
		#1;
		chk(bsy, 1'b1);
		@(posedge clk);
		dn <= 1'b1;
		@(posedge clk);
		dn <= 1'b0;
		#1;
		chk(bsy, 1'b0);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rdchk(8'h90, 32'h00004844, 1'b0);
		outs(16'h4844, 3'h4);
		rdchk(8'h94, 32'h00004A55, 1'b0);
		rdchk(8'h98, 32'h00004C66, 1'b0);
		rdchk(8'h9C, 32'h00004F77, 1'b0);
		foreach (bad[i]) begin
			apb(1'b1, bad[i], 32'h0000FFFF, 4'hF);
			chk(e, 1'b1);
		end
		// Address field 0x2D does not name slot 5, so refused
		apb(1'b1, 8'h94, 32'h00005A55, 4'h3);
		chk(e, 1'b1);
		rdchk(8'h94, 32'h00004A55, 1'b0);
		apb(1'b1, 8'h98, 32'h0000CD9A, 4'h3);
		rdchk(8'h98, 32'h0000CD9A, 1'b0);
		apb(1'b1, 8'hA0, 32'h00000001, 4'h1);
		repeat (2) @(posedge clk);
		#1;
		outs(16'h4844, 3'h4);
		conv;
		outs(16'h4A55, 3'h5);
		chk(rf, 1'b0);
		conv;
		outs(16'hCD9A, 3'h6);
		conv;
		outs(16'h4844, 3'h4);
		chk(rf, 1'b1);
		apb(1'b1, 8'h98, 32'h00004C66, 4'h3);
		chk(e, 1'b0);
		repeat (3) conv;
		outs(16'h4F77, 3'h7);
		chk(rf, 1'b0);
		conv;
		outs(16'h4844, 3'h4);
		chk(rf, 1'b1);
		end_of_test;
	end
endmodule // tb_sqs_top
`default_nettype wire
